// ===== design/nsl_consts.vh
// Constants of the network status lamp block: offsets, fields, timing, lamp modes, start-up phases.
// Assumes inclusion by bare name from the lamp decoder and top-level design files.
`ifndef NSL_CONSTS_VH
`define NSL_CONSTS_VH

// ----------------------------------------
// Register offsets (byte addresses)
// ----------------------------------------
`define NSL_ADDR_W          8
`define NSL_OFS_CTRL        8'h00
`define NSL_OFS_PRESCALE    8'h04
`define NSL_OFS_STATUS      8'h08
`define NSL_OFS_LAMPS       8'h0C

// ----------------------------------------
// Fields
// ----------------------------------------
`define NSL_CTRL_REINIT_BIT 0
`define NSL_PRESCALE_W      24
`define NSL_DATA_W          32

// ----------------------------------------
// Timing
// ----------------------------------------
`define NSL_CLK_KHZ         40000
`define NSL_FLASH_HALF_MS   250
`define NSL_TEST_STEPS      4

// ----------------------------------------
// Lamp modes
// ----------------------------------------
`define NSL_MODE_W          3
`define NSL_MODE_OFF        3'h0
`define NSL_MODE_GREEN      3'h1
`define NSL_MODE_RED        3'h2
`define NSL_MODE_FLASH_G    3'h3
`define NSL_MODE_FLASH_R    3'h4
`define NSL_MODE_ALT        3'h5

// ----------------------------------------
// Start-up phases
// ----------------------------------------
`define NSL_PH_TEST         2'h0
`define NSL_PH_DIAG         2'h1
`define NSL_PH_RUN          2'h2

`endif

// ===== design/nsl_prescaler.v
// Shared flash prescaler: one tick per half flash period, plus flash phase.
// Assumes a reload value held stable by the register file.
`timescale 1ns/1ps
`default_nettype none

module nsl_prescaler #(
  parameter integer CNT_W = 24
) (
  input  wire             clk_sys_in,
  input  wire             sys_rst_in,
  input  wire             restart_in,
  input  wire [CNT_W-1:0] reload_in,
  output reg              tick_out,
  output reg              phase_out
);

  reg [CNT_W-1:0] cnt_r;

  // ----------------------------------------
  // Down counter, tick at zero
  // ----------------------------------------
  // Restart aligns the first flash with the start of a sequence
  always @(posedge clk_sys_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      cnt_r     <= {CNT_W{1'b0}};
      tick_out  <= 1'b0;
      phase_out <= 1'b0;
    end else if (restart_in) begin
      cnt_r     <= reload_in;
      tick_out  <= 1'b0;
      phase_out <= 1'b0;
    end else if (cnt_r == {CNT_W{1'b0}}) begin
      cnt_r     <= reload_in;
      tick_out  <= 1'b1;
      phase_out <= ~phase_out;
    end else begin
      cnt_r    <= cnt_r - {{(CNT_W-1){1'b0}}, 1'b1};
      tick_out <= 1'b0;
    end
  end

endmodule
`default_nettype wire

// ===== design/nsl_lamp.v
// Bicolour lamp pattern decoder: mode and flash phase to green/red drive.
// Assumes the caller registers the result before it leaves the block.
`timescale 1ns/1ps
`default_nettype none
`include "nsl_consts.vh"

module nsl_lamp (
  input  wire [`NSL_MODE_W-1:0] mode_in,
  input  wire                   phase_in,
  output reg                    green_out,
  output reg                    red_out
);

  // ----------------------------------------
  // Pattern decode
  // ----------------------------------------
  // Alternation uses the same phase as flashing, so lamps stay in step
  always @* begin
    green_out = 1'b0;
    red_out   = 1'b0;
    case (mode_in)
      `NSL_MODE_GREEN:   green_out = 1'b1;
      `NSL_MODE_RED:     red_out   = 1'b1;
      `NSL_MODE_FLASH_G: green_out = phase_in;
      `NSL_MODE_FLASH_R: red_out   = phase_in;
      `NSL_MODE_ALT: begin
        green_out = ~phase_in;
        red_out   = phase_in;
      end
      default: begin
        green_out = 1'b0;
        red_out   = 1'b0;
      end
    endcase
  end

endmodule
`default_nettype wire

// ===== design/nsl_status_top.v
// Status lamp controller: module-state, network-state and link lamps.
// Assumes condition inputs are synchronous levels from the comms core.
//
// The register offsets and strobed register access are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
`include "nsl_consts.vh"

// Functional notes
// - After start-up run a lamp test on both lamps, then module lamp green.
// - During self-diagnosis both lamps alternate green and red.
// - Unrecoverable error: module lamp steady red until reinitialisation.
// - Recoverable fault or address conflict: module lamp flashes red, self-clearing.
// - No address assigned: network lamp dark.
// - Process active: network lamp green; awaiting clients: flashing green; neither: network lamp dark.
// - Major fault or address conflict: network lamp steady red until reinit.
// - Exchange timeout: network lamp flashes red.
// - No physical link: link lamp dark.
// - Link without traffic: link lamp green; traffic: link lamp flashes green.
module nsl_status_top #(
  parameter integer FLASH_HALF_CYC = `NSL_FLASH_HALF_MS * `NSL_CLK_KHZ,
  parameter integer TEST_STEPS     = `NSL_TEST_STEPS
) (
  input  wire                    clk_sys_in,
  input  wire                    sys_rst_in,
  input  wire [`NSL_ADDR_W-1:0]  reg_addr_in,
  input  wire [`NSL_DATA_W-1:0]  reg_wdata_in,
  input  wire                    reg_wr_in,
  input  wire                    reg_rd_in,
  output reg  [`NSL_DATA_W-1:0]  reg_rdata_out,
  input  wire                    selftest_busy_in,
  input  wire                    fault_fatal_in,
  input  wire                    fault_recov_in,
  input  wire                    ip_conflict_in,
  input  wire                    ip_assigned_in,
  input  wire                    proc_active_in,
  input  wire                    conn_wait_in,
  input  wire                    xchg_timeout_in,
  input  wire                    link_up_in,
  input  wire                    link_traffic_in,
  output reg                     module_state_lamp_green_out,
  output reg                     module_state_lamp_red_out,
  output reg                     network_state_lamp_green_out,
  output reg                     network_state_lamp_red_out,
  output reg                     link_lamp_green_out
);

  // ----------------------------------------
  // Declarations
  // ----------------------------------------
  localparam integer               PRESCALE_INI = FLASH_HALF_CYC - 1;
  localparam integer               TEST_LAST_I  = TEST_STEPS - 1;
  localparam [`NSL_PRESCALE_W-1:0] PRESCALE_RST = PRESCALE_INI[`NSL_PRESCALE_W-1:0];
  localparam [3:0]                 TEST_LAST    = TEST_LAST_I[3:0];

  reg  [`NSL_PRESCALE_W-1:0] prescale_r;
  reg                        reinit_r;
  reg  [1:0]                 phase_r;
  reg  [1:0]                 phase_nxt;
  reg  [3:0]                 step_r;
  reg  [3:0]                 step_nxt;
  reg                        ms_fatal_r;
  reg                        ns_fatal_r;
  reg  [`NSL_MODE_W-1:0]     ms_mode;
  reg  [`NSL_MODE_W-1:0]     ns_mode;
  reg  [`NSL_MODE_W-1:0]     test_mode;
  reg  [`NSL_DATA_W-1:0]     rdata_nxt;
  wire                       tick;
  wire                       flash_phase;
  wire                       ms_green;
  wire                       ms_red;
  wire                       ns_green;
  wire                       ns_red;
  reg                        boot_r;
  reg  [`NSL_MODE_W-1:0]     link_mode;
  wire                       restart;
  wire                       link_green;

  // Full-address exact-match decode shared by reads and writes
  function hit;
    input [`NSL_ADDR_W-1:0] addr;
    input [`NSL_ADDR_W-1:0] ofs;
    begin
      hit = (addr == ofs);
    end
  endfunction

  // ----------------------------------------
  // Register writes
  // ----------------------------------------
  // Reinit is a one-cycle self-clearing pulse, it never reads back as set
  always @(posedge clk_sys_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      prescale_r <= PRESCALE_RST;
      reinit_r   <= 1'b0;
    end else begin
      reinit_r <= reg_wr_in && hit(reg_addr_in, `NSL_OFS_CTRL)
                  && reg_wdata_in[`NSL_CTRL_REINIT_BIT];
      if (reg_wr_in && hit(reg_addr_in, `NSL_OFS_PRESCALE)) begin
        prescale_r <= reg_wdata_in[`NSL_PRESCALE_W-1:0];
      end
    end
  end

  // ----------------------------------------
  // Start-of-run pulse
  // ----------------------------------------
  // Without it the cleared counter ticks at once and the first
  // lamp test step would last a single cycle
  always @(posedge clk_sys_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      boot_r <= 1'b1;
    end else begin
      boot_r <= 1'b0;
    end
  end

  assign restart = reinit_r | boot_r;

  // ----------------------------------------
  // Shared flash prescaler
  // ----------------------------------------
  nsl_prescaler #(
    .CNT_W (`NSL_PRESCALE_W)
  ) u_prescaler (
    .clk_sys_in (clk_sys_in),
    .sys_rst_in (sys_rst_in),
    .restart_in (restart),
    .reload_in  (prescale_r),
    .tick_out   (tick),
    .phase_out  (flash_phase)
  );

  // ----------------------------------------
  // Start-up sequence
  // ----------------------------------------
  // Test steps advance on prescaler ticks; diagnosis holds while busy
  always @* begin
    phase_nxt = phase_r;
    step_nxt  = step_r;
    case (phase_r)
      `NSL_PH_TEST: begin
        if (tick) begin
          if (step_r == TEST_LAST) begin
            step_nxt  = 4'h0;
            phase_nxt = `NSL_PH_DIAG;
          end else begin
            step_nxt = step_r + 4'h1;
          end
        end
      end
      `NSL_PH_DIAG: begin
        if (!selftest_busy_in) begin
          phase_nxt = `NSL_PH_RUN;
        end
      end
      `NSL_PH_RUN: begin
        phase_nxt = `NSL_PH_RUN;
      end
      default: begin
        phase_nxt = `NSL_PH_TEST;
        step_nxt  = 4'h0;
      end
    endcase
    if (reinit_r) begin
      phase_nxt = `NSL_PH_TEST;
      step_nxt  = 4'h0;
    end
  end

  always @(posedge clk_sys_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      phase_r <= `NSL_PH_TEST;
      step_r  <= 4'h0;
    end else begin
      phase_r <= phase_nxt;
      step_r  <= step_nxt;
    end
  end

  // ----------------------------------------
  // Sticky fault latches
  // ----------------------------------------
  // A fault in the reinit cycle still latches: set beats clear
  always @(posedge clk_sys_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      ms_fatal_r <= 1'b0;
      ns_fatal_r <= 1'b0;
    end else begin
      ms_fatal_r <= fault_fatal_in | (ms_fatal_r & ~reinit_r);
      ns_fatal_r <= fault_fatal_in | ip_conflict_in
                    | (ns_fatal_r & ~reinit_r);
    end
  end

  // ----------------------------------------
  // Lamp test pattern
  // ----------------------------------------
  // Green, red, green, red... one step per tick
  always @* begin
    if (step_r[0]) begin
      test_mode = `NSL_MODE_RED;
    end else begin
      test_mode = `NSL_MODE_GREEN;
    end
  end

  // ----------------------------------------
  // Module-state lamp selection
  // ----------------------------------------
  // Red causes are checked first so they mask any green state
  always @* begin
    case (phase_r)
      `NSL_PH_TEST: ms_mode = test_mode;
      `NSL_PH_DIAG: ms_mode = `NSL_MODE_ALT;
      default: begin
        if (ms_fatal_r) begin
          ms_mode = `NSL_MODE_RED;
        end else if (fault_recov_in || ip_conflict_in) begin
          ms_mode = `NSL_MODE_FLASH_R;
        end else begin
          ms_mode = `NSL_MODE_GREEN;
        end
      end
    endcase
  end

  // ----------------------------------------
  // Network-state lamp selection
  // ----------------------------------------
  // Conflict shows red even before an address is in use
  always @* begin
    case (phase_r)
      `NSL_PH_TEST: ns_mode = test_mode;
      `NSL_PH_DIAG: ns_mode = `NSL_MODE_ALT;
      default: begin
        if (ns_fatal_r) begin
          ns_mode = `NSL_MODE_RED;
        end else if (!ip_assigned_in) begin
          ns_mode = `NSL_MODE_OFF;
        end else if (xchg_timeout_in) begin
          ns_mode = `NSL_MODE_FLASH_R;
        end else if (proc_active_in) begin
          ns_mode = `NSL_MODE_GREEN;
        end else if (conn_wait_in) begin
          ns_mode = `NSL_MODE_FLASH_G;
        end else begin
          ns_mode = `NSL_MODE_OFF;
        end
      end
    endcase
  end

  // ----------------------------------------
  // Link lamp selection
  // ----------------------------------------
  // Follows the wire only, so it runs through the start-up phases too
  always @* begin
    if (!link_up_in) begin
      link_mode = `NSL_MODE_OFF;
    end else if (link_traffic_in) begin
      link_mode = `NSL_MODE_FLASH_G;
    end else begin
      link_mode = `NSL_MODE_GREEN;
    end
  end

  // ----------------------------------------
  // Pattern decoders
  // ----------------------------------------
  nsl_lamp u_ms_lamp (
    .mode_in   (ms_mode),
    .phase_in  (flash_phase),
    .green_out (ms_green),
    .red_out   (ms_red)
  );

  nsl_lamp u_ns_lamp (
    .mode_in   (ns_mode),
    .phase_in  (flash_phase),
    .green_out (ns_green),
    .red_out   (ns_red)
  );

  // Link lamp is green only, its red drive is left open
  nsl_lamp u_link_lamp (
    .mode_in   (link_mode),
    .phase_in  (flash_phase),
    .green_out (link_green),
    .red_out   ()
  );

  // ----------------------------------------
  // Registered lamp outputs
  // ----------------------------------------
  // One flop stage per lamp keeps the pins free of decode glitches
  always @(posedge clk_sys_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      module_state_lamp_green_out  <= 1'b0;
      module_state_lamp_red_out    <= 1'b0;
      network_state_lamp_green_out <= 1'b0;
      network_state_lamp_red_out   <= 1'b0;
      link_lamp_green_out          <= 1'b0;
    end else begin
      module_state_lamp_green_out  <= ms_green;
      module_state_lamp_red_out    <= ms_red;
      network_state_lamp_green_out <= ns_green;
      network_state_lamp_red_out   <= ns_red;
      link_lamp_green_out          <= link_green;
    end
  end

  // ----------------------------------------
  // Register reads
  // ----------------------------------------
  // Unmapped addresses and idle cycles return zero
  always @* begin
    rdata_nxt = {`NSL_DATA_W{1'b0}};
    if (reg_rd_in) begin
      if (hit(reg_addr_in, `NSL_OFS_PRESCALE)) begin
        rdata_nxt[`NSL_PRESCALE_W-1:0] = prescale_r;
      end else if (hit(reg_addr_in, `NSL_OFS_STATUS)) begin
        rdata_nxt[1:0]   = phase_r;
        rdata_nxt[2]     = ms_fatal_r;
        rdata_nxt[3]     = ns_fatal_r;
        rdata_nxt[4]     = flash_phase;
        rdata_nxt[11:8]  = step_r;
      end else if (hit(reg_addr_in, `NSL_OFS_LAMPS)) begin
        rdata_nxt[2:0]   = ms_mode;
        rdata_nxt[6:4]   = ns_mode;
        rdata_nxt[8]     = module_state_lamp_green_out;
        rdata_nxt[9]     = module_state_lamp_red_out;
        rdata_nxt[10]    = network_state_lamp_green_out;
        rdata_nxt[11]    = network_state_lamp_red_out;
        rdata_nxt[12]    = link_lamp_green_out;
      end else begin
        rdata_nxt = {`NSL_DATA_W{1'b0}};
      end
    end
  end

  always @(posedge clk_sys_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      reg_rdata_out <= {`NSL_DATA_W{1'b0}};
    end else begin
      reg_rdata_out <= rdata_nxt;
    end
  end

endmodule
`default_nettype wire

// ===== testbench/nsl_panel_model.sv
// Front-panel lamp model: shows the lit lamps and counts changes of one of them.
// Assumes the five lamp drives of the status block, high meaning lit.
`timescale 1ns/1ps
`default_nettype none

module nsl_panel_model (
  input  wire logic       clk_in,
  input  wire logic       clr_in,
  input  wire logic [2:0] sel_in,
  input  wire logic [4:0] lamp_in,
  output logic      [4:0] lit_out,
  output logic      [7:0] flip_out
);
  logic prev_r;

  // A real lamp shows its drive at once
  assign lit_out = lamp_in;

  // Change counter; a blink shows as two changes per period
  always @(posedge clk_in) begin
    prev_r <= lamp_in[sel_in];
    if (clr_in)
      flip_out <= 8'h00;
    else if (lamp_in[sel_in] != prev_r)
      flip_out <= flip_out + 8'h01;
  end
endmodule

`default_nettype wire

// ===== testbench/nsl_status_props.sv
// Checker of the status lamp block, bound to its top module.
// Assumes lamp reload never written above its reset value.
`timescale 1ns/1ps
`default_nettype none

module nsl_status_props #(
  parameter integer FLASH_HALF_CYC = 8
) (
  input wire logic        clk_sys_in,
  input wire logic        sys_rst_in,
  input wire logic [7:0]  reg_addr_in,
  input wire logic [31:0] reg_wdata_in,
  input wire logic        reg_wr_in,
  input wire logic        reg_rd_in,
  input wire logic [31:0] reg_rdata_out,
  input wire logic        fault_fatal_in,
  input wire logic        fault_recov_in,
  input wire logic        ip_conflict_in,
  input wire logic        ip_assigned_in,
  input wire logic        proc_active_in,
  input wire logic        xchg_timeout_in,
  input wire logic        link_up_in,
  input wire logic        link_traffic_in,
  input wire logic        module_state_lamp_green_out,
  input wire logic        module_state_lamp_red_out,
  input wire logic        network_state_lamp_green_out,
  input wire logic        network_state_lamp_red_out,
  input wire logic        link_lamp_green_out
);
  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (sys_rst_in);

  logic       stat_q;
  logic       run_r;
  logic       lat_r;
  logic [7:0] stall_r;
  wire        reinit_w = reg_wr_in && reg_addr_in == 8'h00 && reg_wdata_in[0];
  wire        run_ok = run_r && !reinit_w;

  // Run phase is learnt from a status read, since phase is not at the pins
  always @(posedge clk_sys_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      stat_q  <= 1'b0;
      run_r   <= 1'b0;
      lat_r   <= 1'b0;
      stall_r <= 8'h00;
    end else begin
      stat_q  <= reg_rd_in && reg_addr_in == 8'h08;
      run_r   <= !reinit_w && (run_r || (stat_q && reg_rdata_out[1:0] == 2'h2));
      lat_r   <= fault_fatal_in || ip_conflict_in || (lat_r && !reinit_w);
      stall_r <= (link_up_in && link_traffic_in && $stable(link_lamp_green_out)) ? stall_r + 8'h01 : 8'h00;
    end
  end

  sequence s_fatal_hit;
    run_ok && fault_fatal_in;
  endsequence
  sequence s_ms_red;
    module_state_lamp_red_out && !module_state_lamp_green_out;
  endsequence

  property p_fatal;
    s_fatal_hit |-> ##2 s_ms_red [*8];
  endproperty
  a_fatal: assert property (p_fatal) else $error("module lamp not held red after fatal error");
  property p_recov;
    run_ok && !lat_r && !fault_fatal_in && (fault_recov_in || ip_conflict_in) |=> !module_state_lamp_green_out;
  endproperty
  a_recov: assert property (p_recov) else $error("module lamp green during fault");
  property p_noip;
    run_ok && !lat_r && !ip_assigned_in && !ip_conflict_in && !fault_fatal_in
      |=> !network_state_lamp_green_out && !network_state_lamp_red_out;
  endproperty
  a_noip: assert property (p_noip) else $error("network lamp lit without address");
  property p_ns_green;
    run_ok && !lat_r && ip_assigned_in && proc_active_in && !xchg_timeout_in && !ip_conflict_in && !fault_fatal_in
      |=> network_state_lamp_green_out && !network_state_lamp_red_out;
  endproperty
  a_ns_green: assert property (p_ns_green) else $error("network lamp not green when active");
  property p_link_off;
    !link_up_in |=> !link_lamp_green_out;
  endproperty
  a_link_off: assert property (p_link_off) else $error("link lamp lit without link");
  property p_link_green;
    link_up_in && !link_traffic_in |=> link_lamp_green_out;
  endproperty
  a_link_green: assert property (p_link_green) else $error("link lamp dark with idle link");
  property p_link_flash;
    stall_r <= 2 * FLASH_HALF_CYC;
  endproperty
  a_link_flash: assert property (p_link_flash) else $error("link lamp not flashing with traffic");
  property p_excl;
    !(module_state_lamp_green_out && module_state_lamp_red_out)
      && !(network_state_lamp_green_out && network_state_lamp_red_out);
  endproperty
  a_excl: assert property (p_excl) else $error("lamp shows both colours");
  property p_rd_zero;
    !reg_rd_in |=> reg_rdata_out == 32'h0000_0000;
  endproperty
  a_rd_zero: assert property (p_rd_zero) else $error("read data outside read answer");
endmodule

bind nsl_status_top nsl_status_props #(.FLASH_HALF_CYC(FLASH_HALF_CYC)) u_props (
  .clk_sys_in(clk_sys_in), .sys_rst_in(sys_rst_in), .reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in),
  .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in), .reg_rdata_out(reg_rdata_out), .fault_fatal_in(fault_fatal_in),
  .fault_recov_in(fault_recov_in), .ip_conflict_in(ip_conflict_in), .ip_assigned_in(ip_assigned_in),
  .proc_active_in(proc_active_in), .xchg_timeout_in(xchg_timeout_in), .link_up_in(link_up_in),
  .link_traffic_in(link_traffic_in), .module_state_lamp_green_out(module_state_lamp_green_out),
  .module_state_lamp_red_out(module_state_lamp_red_out), .network_state_lamp_green_out(network_state_lamp_green_out),
  .network_state_lamp_red_out(network_state_lamp_red_out), .link_lamp_green_out(link_lamp_green_out));

`default_nettype wire

// ===== testbench/test_network_module_status_leds.sv
// Testbench of the status lamp block: register calls and lamp pattern checks.
// Assumes a half flash period of 8 cycles, shortened from the real count.
`timescale 1ns/1ps
`default_nettype none

module test_network_module_status_leds;
  logic clk = 1'b0, rst = 1'b1, wr = 1'b0, rd = 1'b0, clr = 1'b0;
  logic busy = 1'b1, fat = 1'b0, rec = 1'b0, cnf = 1'b0, ip = 1'b0;
  logic act = 1'b0, cw = 1'b0, tmo = 1'b0, lu = 1'b0, tr = 1'b0;
  logic [7:0] addr = 8'h00;
  logic [31:0] wd = 32'h0000_0000;
  logic [2:0] sel = 3'h0;
  wire [31:0] rdata;
  wire [4:0] lamp, lit;
  wire [7:0] flip;
  int n_mismatch = 0, total_checks = 0;

  // 40 MHz system clock
  always #12.5 clk = ~clk;

  nsl_status_top #(.FLASH_HALF_CYC(8), .TEST_STEPS(4)) uut (
    .clk_sys_in(clk), .sys_rst_in(rst), .reg_addr_in(addr), .reg_wdata_in(wd), .reg_wr_in(wr), .reg_rd_in(rd),
    .reg_rdata_out(rdata), .selftest_busy_in(busy), .fault_fatal_in(fat), .fault_recov_in(rec),
    .ip_conflict_in(cnf), .ip_assigned_in(ip), .proc_active_in(act), .conn_wait_in(cw),
    .xchg_timeout_in(tmo), .link_up_in(lu), .link_traffic_in(tr),
    .module_state_lamp_green_out(lamp[4]), .module_state_lamp_red_out(lamp[3]),
    .network_state_lamp_green_out(lamp[2]), .network_state_lamp_red_out(lamp[1]), .link_lamp_green_out(lamp[0]));

  nsl_panel_model u_panel (.clk_in(clk), .clr_in(clr), .sel_in(sel), .lamp_in(lamp), .lit_out(lit), .flip_out(flip));

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask
  // One-cycle strobes; the slave never stalls
  task automatic wrr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    wr <= 1'b1; addr <= a; wd <= d;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  // Read data stands only in the cycle after the strobe
  task automatic rdc(input logic [7:0] a, input logic [31:0] m, input logic [31:0] exp);
    @(posedge clk);
    rd <= 1'b1; addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    #1 chk(rdata & m, exp);
  endtask
  task automatic lampchk(input logic [4:0] exp);
    cyc(3);
    #1 chk(lit, exp);
  endtask
  // Counts lamp changes over 32 cycles; a window edge may add or drop one
  task automatic flips(input logic [2:0] s, input int lo, input int hi);
    @(posedge clk);
    clr <= 1'b1; sel <= s;
    @(posedge clk);
    clr <= 1'b0;
    cyc(32);
    #1 chk(flip >= lo && flip <= hi, 1);
  endtask
  task summarize;
    $display("Checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  // Hang guard
  initial begin
    #125000;
    n_mismatch++;
    summarize;
  end

  // Main sequence
  initial begin
    cyc(8);
    #1 chk(lit, 5'b00000);
    @(posedge clk) rst <= 1'b0;
    cyc(4); #1 chk(lit, 5'b10100);
    cyc(8); #1 chk(lit, 5'b01010);
    cyc(22);
    flips(3'h4, 3, 5);
    flips(3'h1, 3, 5);
    @(posedge clk) begin busy <= 1'b0; ip <= 1'b1; act <= 1'b1; lu <= 1'b1; end
    lampchk(5'b10101);
    rdc(8'h08, 32'h0000_0003, 32'h0000_0002);
    rdc(8'h04, 32'hFFFF_FFFF, 32'h0000_0007);
    $display("Start-up test done");
    @(posedge clk) tr <= 1'b1;
    flips(3'h0, 3, 5);
    @(posedge clk) lu <= 1'b0;
    lampchk(5'b10100);
    @(posedge clk) begin lu <= 1'b1; tr <= 1'b0; act <= 1'b0; cw <= 1'b1; end
    flips(3'h2, 3, 5);
    @(posedge clk) tmo <= 1'b1;
    flips(3'h1, 3, 5);
    flips(3'h2, 0, 0);
    @(posedge clk) begin tmo <= 1'b0; ip <= 1'b0; end
    lampchk(5'b10001);
    $display("Network and link test done");
    @(posedge clk) begin ip <= 1'b1; act <= 1'b1; rec <= 1'b1; end
    flips(3'h3, 3, 5);
    flips(3'h4, 0, 0);
    @(posedge clk) rec <= 1'b0;
    lampchk(5'b10101);
    wrr(8'h04, 32'hFF00_0003);
    rdc(8'h04, 32'hFFFF_FFFF, 32'h0000_0003);
    @(posedge clk) tr <= 1'b1;
    flips(3'h0, 7, 9);
    @(posedge clk) tr <= 1'b0;
    rdc(8'h10, 32'hFFFF_FFFF, 32'h0000_0000);
    rdc(8'h00, 32'hFFFF_FFFF, 32'h0000_0000);
    $display("Fault and prescaler test done");
    @(posedge clk) fat <= 1'b1;
    @(posedge clk) fat <= 1'b0;
    lampchk(5'b01011);
    cyc(20); #1 chk(lit, 5'b01011);
    wrr(8'h00, 32'h0000_0001);
    cyc(2); #1 chk(lit, 5'b10101);
    cyc(20);
    @(posedge clk) cnf <= 1'b1;
    flips(3'h3, 7, 9);
    chk(lit[1], 1'b1);
    @(posedge clk) cnf <= 1'b0;
    cyc(4); #1 chk(lit[1], 1'b1);
    chk(lit[4], 1'b1);
    $display("Fatal and conflict test done");
    summarize;
  end
endmodule

`default_nettype wire
